/* File: include/pef_pkg.sv */
// Package for the power event flag and interrupt pin configuration block.
// Assumes a single 20 MHz system clock and an 8-bit special-function register bus.
package pef_pkg;

    // Register byte addresses on the special-function register bus
    localparam logic [7:0] PEF_ADDR_FLAGS    = 8'hF8;
    localparam logic [7:0] PEF_ADDR_ENABLES  = 8'hEC;
    localparam logic [7:0] PEF_ADDR_KEY      = 8'hC1;
    localparam logic [7:0] PEF_ADDR_PINCFG   = 8'hFF;

    // Bit addresses of the flag register start at its byte address
    localparam logic [4:0] PEF_BIT_BASE      = 5'h1F;

    // Unlock value of the write key register
    localparam logic [7:0] PEF_KEY_UNLOCK    = 8'hEA;

    // Values after reset
    localparam logic [7:0] PEF_RST_FLAGS     = 8'h00;
    localparam logic [7:0] PEF_RST_ENABLES   = 8'h00;
    localparam logic [7:0] PEF_RST_KEY       = 8'h00;
    localparam logic [7:0] PEF_RST_PINCFG    = 8'h00;

    // Implemented bits; reserved bits read as zero
    localparam logic [7:0] PEF_MASK_FLAGS    = 8'hEF;
    localparam logic [7:0] PEF_MASK_ENABLES  = 8'hAF;
    localparam logic [7:0] PEF_MASK_PINCFG   = 8'hEF;

    // Field positions in the pin configuration register
    localparam int PEF_CAL_EN_BIT            = 7;
    localparam int PEF_CAL_FREQ_SELECT_LSB              = 5;
    localparam int PEF_EXTERNAL_INTERRUPT_ONE_LSB              = 1;
    localparam int PEF_EXTERNAL_INTERRUPT_ZERO_BIT              = 0;

    // Field positions in the flag register
    localparam int PEF_F_RESTORED            = 7;
    localparam int PEF_F_SUMMARY             = 6;
    localparam int PEF_F_SAG                 = 5;
    localparam int PEF_F_DC_ADC              = 3;
    localparam int PEF_F_BATTERY             = 2;
    localparam int PEF_F_SWITCHOVER          = 1;
    localparam int PEF_F_DC_LOW              = 0;

    // Positions in the synchronised input vector
    localparam int PEF_IN_ON_BATTERY         = 0;
    localparam int PEF_IN_SAG                = 1;
    localparam int PEF_IN_DC_CHANGE          = 2;
    localparam int PEF_IN_DC_READY           = 3;
    localparam int PEF_IN_BAT_LOW            = 4;
    localparam int PEF_IN_BAT_READY          = 5;
    localparam int PEF_IN_DC_LOW             = 6;
    localparam int PEF_IN_EXTERNAL_INTERRUPT_ZERO               = 7;
    localparam int PEF_IN_EXTERNAL_INTERRUPT_ONE               = 8;
    localparam int PEF_IN_COUNT              = 9;

    // Calibration output frequencies and half periods in clock cycles
    localparam int PEF_CLK_HZ                = 20000000;
    localparam int PEF_CAL_F0_HZ             = 1;
    localparam int PEF_CAL_F1_HZ             = 512;
    localparam int PEF_CAL_F2_HZ             = 500;
    localparam int PEF_CAL_F3_HZ             = 16000;
    localparam int PEF_CAL_HALF0             = PEF_CLK_HZ / (2 * PEF_CAL_F0_HZ);
    localparam int PEF_CAL_HALF1             = PEF_CLK_HZ / (2 * PEF_CAL_F1_HZ);
    localparam int PEF_CAL_HALF2             = PEF_CLK_HZ / (2 * PEF_CAL_F2_HZ);
    localparam int PEF_CAL_HALF3             = PEF_CLK_HZ / (2 * PEF_CAL_F3_HZ);
    localparam int PEF_CAL_CNT_W             = 24;

    // Calibration frequency selections
    typedef enum logic [1:0] {
        PEF_CAL_1HZ   = 2'b00,
        PEF_CAL_512HZ = 2'b01,
        PEF_CAL_500HZ = 2'b10,
        PEF_CAL_16KHZ = 2'b11
    } pef_cal_sel_t;

endpackage : pef_pkg

/* File: logic/pef_cal_gen.sv */
// Calibration square-wave generator for the shared calibration output pin.
// Assumes enable and select come from flip-flops on the same clock.
`timescale 1ns/10ps
`default_nettype none
module pef_cal_gen #(
    parameter int HALF0 = pef_pkg::PEF_CAL_HALF0,
    parameter int HALF1 = pef_pkg::PEF_CAL_HALF1,
    parameter int HALF2 = pef_pkg::PEF_CAL_HALF2,
    parameter int HALF3 = pef_pkg::PEF_CAL_HALF3
) (
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 enable,
    input  wire pef_pkg::pef_cal_sel_t sel,
    output var  logic                 wave
);
    import pef_pkg::*;

    typedef struct packed {
        logic [PEF_CAL_CNT_W-1:0] cnt;
        logic                     wave;
    } pef_gen_state_t;

    pef_gen_state_t st_ff;
    pef_gen_state_t nxt_st;
    logic [PEF_CAL_CNT_W-1:0] half_last;

    // Last count of a half period for the chosen frequency
    always_comb begin
        case (sel)
            PEF_CAL_1HZ:   half_last = PEF_CAL_CNT_W'(HALF0 - 1);
            PEF_CAL_512HZ: half_last = PEF_CAL_CNT_W'(HALF1 - 1);
            PEF_CAL_500HZ: half_last = PEF_CAL_CNT_W'(HALF2 - 1);
            PEF_CAL_16KHZ: half_last = PEF_CAL_CNT_W'(HALF3 - 1);
            default:       half_last = PEF_CAL_CNT_W'(HALF0 - 1);
        endcase
    end

    // Count half periods; held low and cleared while disabled
    always_comb begin
        nxt_st = st_ff;
        if (!enable) begin
            nxt_st.cnt  = '0;
            nxt_st.wave = 1'b0;
        end else if (st_ff.cnt >= half_last) begin
            nxt_st.cnt  = '0;
            nxt_st.wave = !st_ff.wave;
        end else begin
            nxt_st.cnt = st_ff.cnt + PEF_CAL_CNT_W'(1);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wave = st_ff.wave;

endmodule : pef_cal_gen
`default_nettype wire

/* File: logic/pef_power_flags.sv */
// Power event flags, their enables, the write key and the interrupt pin configuration.
// Assumes the core drives the register bus on this clock; event and pin inputs are asynchronous.
// Overview of operation
// - Calibration enable drives selected frequency onto pin
// - Two-bit select picks calibration output frequency
// - Three-bit field picks external interrupt one function
// - Bit zero enables external interrupt zero
// - Pin configuration writable only after key unlock
// - Flag seven set when supply returns from battery
// - Summary flag set by any enabled event
// - Flag five set on line voltage sag
// - Flag three set on DC change or ready
// - Flag two set on battery low or ready
// - Flag one set on switch to battery
// - Flag zero set when DC input falls low
// - Enable register gates events into summary flag
`timescale 1ns/10ps
`default_nettype none
module pef_power_flags #(
    parameter int CAL_HALF0 = pef_pkg::PEF_CAL_HALF0,
    parameter int CAL_HALF1 = pef_pkg::PEF_CAL_HALF1,
    parameter int CAL_HALF2 = pef_pkg::PEF_CAL_HALF2,
    parameter int CAL_HALF3 = pef_pkg::PEF_CAL_HALF3
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output var  logic [7:0] sfr_rdata,
    input  wire logic       bit_wr,
    input  wire logic [7:0] bit_addr,
    input  wire logic       bit_wdata,
    input  wire logic       supply_on_battery,
    input  wire logic       sag_detect,
    input  wire logic       dc_input_change,
    input  wire logic       dc_input_ready,
    input  wire logic       battery_low,
    input  wire logic       battery_ready,
    input  wire logic       dc_input_low,
    input  wire logic       external_interrupt_zero,
    input  wire logic       external_interrupt_one,
    output var  logic       cal_pin_out,
    output var  logic       cal_pin_oe,
    output var  logic       ext_irq_zero_req,
    output var  logic       ext_irq_one_req,
    output var  logic       ext_irq_one_gpio,
    output var  logic       battery_control_function,
    output var  logic       power_summary_irq
);
    import pef_pkg::*;

    typedef struct packed {
        logic [PEF_IN_COUNT-1:0] sync1;
        logic [PEF_IN_COUNT-1:0] sync2;
        logic [PEF_IN_COUNT-1:0] prev;
        logic [7:0]              flags;
        logic [7:0]              enables;
        logic [7:0]              key;
        logic [7:0]              pincfg;
        logic [7:0]              rdata;
        logic                    irq0;
        logic                    irq1;
    } pef_state_t;

    pef_state_t              st_ff;
    pef_state_t              nxt_st;
    logic [PEF_IN_COUNT-1:0] raw_in;
    logic [PEF_IN_COUNT-1:0] rise;
    logic [PEF_IN_COUNT-1:0] fall;
    logic [7:0]              ev;
    logic                    sum_set;
    logic                    wr_flags;
    logic                    wr_pincfg;
    logic                    unlocked;
    logic                    bit_hit;

    // Gather asynchronous inputs for the two-stage synchroniser
    assign raw_in = {external_interrupt_one, external_interrupt_zero, dc_input_low, battery_ready,
                     battery_low, dc_input_ready, dc_input_change, sag_detect, supply_on_battery};

    // Edges seen on the second synchroniser stage only
    assign rise = st_ff.sync2 & ~st_ff.prev;
    assign fall = ~st_ff.sync2 & st_ff.prev;

    // Event pulses in flag positions
    always_comb begin
        ev                   = 8'h00;
        ev[PEF_F_RESTORED]   = fall[PEF_IN_ON_BATTERY];
        ev[PEF_F_SAG]        = rise[PEF_IN_SAG];
        ev[PEF_F_DC_ADC]     = rise[PEF_IN_DC_CHANGE] | rise[PEF_IN_DC_READY];
        ev[PEF_F_BATTERY]    = rise[PEF_IN_BAT_LOW] | rise[PEF_IN_BAT_READY];
        ev[PEF_F_SWITCHOVER] = rise[PEF_IN_ON_BATTERY];
        ev[PEF_F_DC_LOW]     = rise[PEF_IN_DC_LOW];
    end

    // Summary flag only for events whose enable is set
    assign sum_set   = |(ev & st_ff.enables);

    // Bus decode
    assign wr_flags  = sfr_wr && (sfr_addr == PEF_ADDR_FLAGS);
    assign wr_pincfg = sfr_wr && (sfr_addr == PEF_ADDR_PINCFG);
    assign unlocked  = (st_ff.key == PEF_KEY_UNLOCK);
    assign bit_hit   = bit_wr && (bit_addr[7:3] == PEF_BIT_BASE);

    // Next state of every register
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sync1 = raw_in;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.prev  = st_ff.sync2;
        // Software writes first, hardware sets override them
        if (wr_flags) begin
            nxt_st.flags = sfr_wdata;
        end
        if (bit_hit) begin
            nxt_st.flags[bit_addr[2:0]] = bit_wdata;
        end
        nxt_st.flags = (nxt_st.flags | ev) & PEF_MASK_FLAGS;
        if (sum_set) begin
            nxt_st.flags[PEF_F_SUMMARY] = 1'b1;
        end
        if (sfr_wr && (sfr_addr == PEF_ADDR_ENABLES)) begin
            nxt_st.enables = sfr_wdata & PEF_MASK_ENABLES;
        end
        if (sfr_wr && (sfr_addr == PEF_ADDR_KEY)) begin
            nxt_st.key = sfr_wdata;
        end
        if (wr_pincfg && unlocked) begin
            nxt_st.pincfg = sfr_wdata & PEF_MASK_PINCFG;
            nxt_st.key    = PEF_RST_KEY;
        end
        // Read data captured on the read strobe
        if (sfr_rd) begin
            case (sfr_addr)
                PEF_ADDR_FLAGS:   nxt_st.rdata = st_ff.flags;
                PEF_ADDR_ENABLES: nxt_st.rdata = st_ff.enables;
                PEF_ADDR_KEY:     nxt_st.rdata = st_ff.key;
                PEF_ADDR_PINCFG:  nxt_st.rdata = st_ff.pincfg;
                default:          nxt_st.rdata = 8'h00;
            endcase
        end
        // External interrupt gating
        nxt_st.irq0 = st_ff.sync2[PEF_IN_EXTERNAL_INTERRUPT_ZERO] & st_ff.pincfg[PEF_EXTERNAL_INTERRUPT_ZERO_BIT];
        nxt_st.irq1 = st_ff.sync2[PEF_IN_EXTERNAL_INTERRUPT_ONE] & (st_ff.pincfg[PEF_EXTERNAL_INTERRUPT_ONE_LSB+2 -: 2] == 2'b11);
    end

    // State register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_ff         <= '0;
            st_ff.flags   <= PEF_RST_FLAGS;
            st_ff.enables <= PEF_RST_ENABLES;
            st_ff.key     <= PEF_RST_KEY;
            st_ff.pincfg  <= PEF_RST_PINCFG;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Calibration frequency generator
    pef_cal_gen #(
        .HALF0 (CAL_HALF0),
        .HALF1 (CAL_HALF1),
        .HALF2 (CAL_HALF2),
        .HALF3 (CAL_HALF3)
    ) u_cal (
        .clock  (clock),
        .reset  (reset),
        .enable (st_ff.pincfg[PEF_CAL_EN_BIT]),
        .sel    (pef_cal_sel_t'(st_ff.pincfg[PEF_CAL_FREQ_SELECT_LSB+1 -: 2])),
        .wave   (cal_pin_out)
    );

    // Outputs
    assign sfr_rdata                = st_ff.rdata;
    assign cal_pin_oe               = st_ff.pincfg[PEF_CAL_EN_BIT];
    assign ext_irq_zero_req         = st_ff.irq0;
    assign ext_irq_one_req          = st_ff.irq1;
    assign ext_irq_one_gpio         = (st_ff.pincfg[PEF_EXTERNAL_INTERRUPT_ONE_LSB+1 -: 2] == 2'b00);
    assign battery_control_function = (st_ff.pincfg[PEF_EXTERNAL_INTERRUPT_ONE_LSB+1 -: 2] == 2'b01);
    assign power_summary_irq        = st_ff.flags[PEF_F_SUMMARY];

    // Checks
    localparam int CAL_FAST_MAX = 626;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_CAL_OFF: assert property (!st_ff.pincfg[7] |=> !cal_pin_out)
        else $error("calibration pin toggles while disabled");
    AST_CAL_FAST: assert property ($rose(cal_pin_out) && st_ff.pincfg[7:5] == 3'b111
        |-> ##[1:CAL_FAST_MAX] (!cal_pin_out || st_ff.pincfg[7:5] != 3'b111))
        else $error("fast calibration half period too long");
    AST_EXTERNAL_INTERRUPT_ONE_GATE: assert property (ext_irq_one_req |-> $past(st_ff.pincfg[3:2]) == 2'b11)
        else $error("external interrupt one passed while not enabled");
    AST_EXTERNAL_INTERRUPT_ZERO_GATE: assert property (ext_irq_zero_req |-> $past(st_ff.pincfg[0]) && $past(st_ff.sync2[7]))
        else $error("external interrupt zero passed while disabled");
    AST_KEY_LOCK: assert property (wr_pincfg && !unlocked |=> $stable(st_ff.pincfg))
        else $error("pin configuration changed without key");
    AST_KEY_OPEN: assert property (wr_pincfg && unlocked |=> st_ff.pincfg == ($past(sfr_wdata) & 8'hEF))
        else $error("unlocked pin configuration write lost");
    AST_KEY_REARM: assert property (wr_pincfg && unlocked |=> st_ff.key == PEF_RST_KEY && !unlocked)
        else $error("key not rearmed after protected write");
    AST_RESTORED: assert property ($fell(st_ff.sync2[0]) |=> st_ff.flags[7])
        else $error("supply restored flag not set");
    AST_SWITCH: assert property ($rose(st_ff.sync2[0]) |=> st_ff.flags[1])
        else $error("switchover flag not set");
    AST_SAG: assert property ($rose(sag_detect) ##2 1'b1 |=> st_ff.flags[5] || $past(st_ff.prev[1]))
        else $error("sag flag not set");
    AST_DC_ADC: assert property (rise[2] || rise[3] |=> st_ff.flags[3])
        else $error("dc input measurement flag not set");
    AST_BATTERY: assert property (rise[4] || rise[5] |=> st_ff.flags[2])
        else $error("battery monitor flag not set");
    AST_DC_LOW: assert property (rise[6] |=> st_ff.flags[0])
        else $error("dc input low flag not set");
    AST_SUMMARY: assert property (sum_set |=> st_ff.flags[6])
        else $error("summary flag missed an enabled event");
    AST_SUM_GATE: assert property (!st_ff.flags[6] && !sum_set && !wr_flags && !bit_hit
        |=> !st_ff.flags[6])
        else $error("summary flag set without enabled event");
    AST_STICKY: assert property (st_ff.flags[2] && !wr_flags && !bit_hit |=> st_ff.flags[2])
        else $error("battery flag dropped without a clear");

    COV_CAL_FAST: cover property ($rose(cal_pin_out) && st_ff.pincfg[6:5] == 2'b11);
    COV_UNLOCK: cover property (wr_pincfg && unlocked);
    COV_SUMMARY: cover property ($rose(st_ff.flags[6]));
    COV_RESTORE: cover property ($fell(st_ff.sync2[0]));

endmodule : pef_power_flags
`default_nettype wire

/* File: test/pef_power_flags_tb_top.sv */
// Testbench for the power event flags and interrupt pin configuration block.
// Assumes the design package is compiled first; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
module pef_power_flags_tb_top;
    import pef_pkg::*;

    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } pef_row_t;

    logic       clock     = 1'b0;
    logic       reset     = 1'b1;
    logic [7:0] sfr_addr  = 8'h00;
    logic       sfr_wr    = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_rd    = 1'b0;
    logic [7:0] sfr_rdata;
    logic       bit_wr    = 1'b0;
    logic [7:0] bit_addr  = 8'h00;
    logic       bit_wdata = 1'b0;
    logic [6:0] ev        = 7'h00;
    logic       pin0      = 1'b0;
    logic       pin1      = 1'b0;
    logic       cal_pin_out, cal_pin_oe, ext_irq_zero_req, ext_irq_one_req;
    logic       ext_irq_one_gpio, battery_control_function, power_summary_irq;
    int         error_cnt = 0;
    int         n_compared = 0;
    int         halves[4] = '{8, 6, 5, 3};
    int         fbit[7]   = '{5, 3, 3, 2, 2, 0, 1};
    pef_row_t   rows[8]   = '{
        '{8'hEC, 8'hFF, 8'hAF}, '{8'hEC, 8'h00, 8'h00}, '{8'hC1, 8'h5A, 8'h5A}, '{8'hFF, 8'hFF, 8'h00},
        '{8'hF8, 8'hEF, 8'hEF}, '{8'hF8, 8'h00, 8'h00}, '{8'h10, 8'hFF, 8'h00}, '{8'hC1, 8'h00, 8'h00}};

    // Clock of 50 ns period
    always #25 clock = ~clock;

    pef_power_flags #(.CAL_HALF0(8), .CAL_HALF1(6), .CAL_HALF2(5), .CAL_HALF3(3)) pef_power_flags_inst (
        .clock(clock), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .bit_wr(bit_wr), .bit_addr(bit_addr), .bit_wdata(bit_wdata),
        .supply_on_battery(ev[6]), .sag_detect(ev[0]), .dc_input_change(ev[1]), .dc_input_ready(ev[2]),
        .battery_low(ev[3]), .battery_ready(ev[4]), .dc_input_low(ev[5]),
        .external_interrupt_zero(pin0), .external_interrupt_one(pin1), .cal_pin_out(cal_pin_out),
        .cal_pin_oe(cal_pin_oe), .ext_irq_zero_req(ext_irq_zero_req), .ext_irq_one_req(ext_irq_one_req),
        .ext_irq_one_gpio(ext_irq_one_gpio), .battery_control_function(battery_control_function),
        .power_summary_irq(power_summary_irq));

    // Compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // One byte write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_wr <= 1'b1; sfr_addr <= a; sfr_wdata <= d;
        @(posedge clock);
        sfr_wr <= 1'b0;
    endtask : wr

    // One byte read, checked once the data has settled
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clock);
        sfr_rd <= 1'b1; sfr_addr <= a;
        @(posedge clock);
        sfr_rd <= 1'b0;
        @(negedge clock);
        check(name, sfr_rdata, exp);
    endtask : rd_chk

    // Single flag bit write
    task automatic bit_write(input int b, input logic v);
        @(posedge clock);
        bit_wr <= 1'b1; bit_addr <= 8'(PEF_ADDR_FLAGS + b); bit_wdata <= v;
        @(posedge clock);
        bit_wr <= 1'b0;
    endtask : bit_write

    // Unlocked write of the pin configuration
    task automatic cfg(input logic [7:0] v);
        wr(PEF_ADDR_KEY, PEF_KEY_UNLOCK);
        wr(PEF_ADDR_PINCFG, v);
    endtask : cfg

    // Cycles between two changes of the calibration wave
    task automatic cal_meas(input int sel);
        int n;
        logic lv;
        cfg(8'h80 | 8'(sel << 5));
        @(negedge clock);
        // First pass finds a change, second counts one full half period
        for (int k = 0; k < 2; k++) begin
            lv = cal_pin_out;
            n = 0;
            while (cal_pin_out === lv && n < 100) begin
                @(negedge clock);
                n++;
            end
            if (n >= 100) begin
                error_cnt++;
                $display("ERROR cal_wait expected toggle seen timeout");
                final_report();
            end
        end
        check("cal_oe", cal_pin_oe, 8'h01);
        check("cal_half", 8'(n), 8'(halves[sel]));
    endtask : cal_meas

    // Hang guard
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        $display("ERROR watchdog expected finish seen timeout");
        final_report();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].exp, "row_readback");
        end
        $display("test register table done");
        cfg(8'h0F);
        rd_chk(PEF_ADDR_KEY, 8'h00, "key_rearm");
        wr(PEF_ADDR_PINCFG, 8'h00);
        rd_chk(PEF_ADDR_PINCFG, 8'h0F, "second_write");
        $display("test key protection done");
        @(posedge clock);
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        for (int v = 0; v < 16; v++) begin
            cfg(8'(v));
            repeat (4) @(negedge clock);
            check("external_interrupt_zero_req", ext_irq_zero_req, 8'(v & 1));
            check("external_interrupt_one_req", ext_irq_one_req, 8'(((v >> 2) & 3) == 3));
            check("external_interrupt_one_gpio", ext_irq_one_gpio, 8'(((v >> 1) & 3) == 0));
            check("external_interrupt_one_battery_control_function", battery_control_function, 8'(((v >> 1) & 3) == 1));
        end
        @(posedge clock);
        pin0 <= 1'b0;
        pin1 <= 1'b0;
        repeat (5) @(negedge clock);
        check("pins_low", {ext_irq_zero_req, ext_irq_one_req}, 8'h00);
        $display("test pin functions done");
        for (int s = 0; s < 4; s++) cal_meas(s);
        cfg(8'h00);
        repeat (2) @(negedge clock);
        check("cal_off", {cal_pin_oe, cal_pin_out}, 8'h00);
        $display("test calibration output done");
        wr(PEF_ADDR_ENABLES, 8'hAF);
        for (int i = 0; i < 7; i++) begin
            @(posedge clock);
            ev[i] <= 1'b1;
            repeat (4) @(posedge clock);
            rd_chk(PEF_ADDR_FLAGS, 8'(1 << fbit[i]) | 8'h40, "event_flag");
            check("summary", power_summary_irq, 8'h01);
            @(posedge clock);
            ev[i] <= 1'b0;
            repeat (4) @(posedge clock);
            rd_chk(PEF_ADDR_FLAGS, 8'(1 << fbit[i]) | 8'h40 | (i == 6 ? 8'h80 : 8'h00), "sticky");
            bit_write(fbit[i], 1'b0);
            bit_write(6, 1'b0);
            bit_write(7, 1'b0);
            rd_chk(PEF_ADDR_FLAGS, 8'h00, "bit_clear");
        end
        wr(PEF_ADDR_ENABLES, 8'h00);
        @(posedge clock);
        ev[0] <= 1'b1;
        repeat (4) @(posedge clock);
        rd_chk(PEF_ADDR_FLAGS, 8'h20, "masked_event");
        check("masked_summary", power_summary_irq, 8'h00);
        $display("test power events done");
        cfg(8'h81);
        @(posedge clock);
        ev    <= 7'h00;
        reset <= 1'b1;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        check("rst_outs", {cal_pin_oe, ext_irq_one_gpio, power_summary_irq}, 8'h02);
        rd_chk(PEF_ADDR_FLAGS, PEF_RST_FLAGS, "rst_flags");
        rd_chk(PEF_ADDR_ENABLES, PEF_RST_ENABLES, "rst_enables");
        rd_chk(PEF_ADDR_PINCFG, PEF_RST_PINCFG, "rst_pincfg");
        $display("test reset done");
        final_report();
    end

endmodule : pef_power_flags_tb_top
`default_nettype wire
